//--- src/swc_sleep_ctrl.sv
// Sleep, wake-up, watchdog and read-out gating controller
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module swc_sleep_ctrl #(
  parameter int WDT_CYCLES = swc_pkg::WDT_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire swc_pkg::swc_core_req_t core_req,
  input wire swc_pkg::swc_irq_t irq,
  input wire logic global_irq_enable,
  input wire logic watchdog_enable_fuse,
  input wire logic osc_rc_mode,
  input wire logic master_clear_pin_n,
  input wire logic verify_mode,
  input wire logic [1:0] code_protect_fuse,
  input wire logic [swc_pkg::PADDR_W-1:0] prog_addr,
  output logic device_reset,
  output logic core_halt,
  output logic osc_drive_on,
  output logic io_hold,
  output logic [swc_pkg::PADDR_W-1:0] prefetch_addr,
  output logic sleep_nop,
  output logic resume_exec,
  output logic vector_req,
  output logic [swc_pkg::PADDR_W-1:0] vector_addr,
  output logic prog_read_allow,
  output logic id_write_allow
);

  localparam int WDT_W = $clog2(WDT_CYCLES + 1);
  localparam int OST_W = $clog2(swc_pkg::OST_CYCLES + 1);

  swc_pkg::swc_state_t st_r, st_nxt;
  logic [7:0] option_r;
  logic pd_n_r, to_n_r;
  logic master_clear_pin_n_s1_r, master_clear_pin_n_s2_r;
  logic [WDT_W-1:0] wdt_cnt_r;
  logic [7:0] post_cnt_r;
  logic [OST_W-1:0] ost_cnt_r;
  logic dummy_cnt_r;
  logic vec_pend_r;
  logic reset_r, nop_r, resume_r, vector_r;
  logic [swc_pkg::PADDR_W-1:0] prefetch_r;
  logic rd_allow_r, id_wr_r;
  logic [7:0] rdata_r;
  logic master_clear_pin_n_act, wake_irq, sleep_take, sleep_nop_c;
  logic base_tmo, wdt_tmo, wdt_clr, ost_done, id_hit;
  logic [7:0] post_limit;

  // Master clear pin through two flip-flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      master_clear_pin_n_s1_r <= 1'b1;
      master_clear_pin_n_s2_r <= 1'b1;
    end else begin
      master_clear_pin_n_s1_r <= master_clear_pin_n;
      master_clear_pin_n_s2_r <= master_clear_pin_n_s1_r;
    end
  end
  assign master_clear_pin_n_act = !master_clear_pin_n_s2_r;

  // Wake only on clockless sources with their own enable set
  assign wake_irq = |(irq.flags & irq.enables
                      & swc_pkg::WAKE_CAPABLE);
  assign sleep_nop_c = (st_r == swc_pkg::SWC_RUN) && core_req.sleep_exec
                       && wake_irq && !master_clear_pin_n_act;
  assign sleep_take = (st_r == swc_pkg::SWC_RUN) && core_req.sleep_exec
                      && !wake_irq && !master_clear_pin_n_act;

  // Watchdog base count and prescaler in postscaler role
  assign post_limit = 8'(({1'b0, 8'h01} << option_r[2:0]) - 9'h001);
  assign base_tmo = watchdog_enable_fuse
                    && (wdt_cnt_r == WDT_W'(WDT_CYCLES - 1));
  assign wdt_tmo = base_tmo && (!option_r[swc_pkg::OPT_PSA_BIT]
                   || post_cnt_r == post_limit);
  assign wdt_clr = sleep_take || core_req.watchdog_clear_instr
                   || master_clear_pin_n_act;

  // Watchdog counter keeps running through sleep
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wdt_cnt_r <= '0;
      post_cnt_r <= 8'h00;
    end else if (wdt_clr || !watchdog_enable_fuse) begin
      wdt_cnt_r <= '0;
      post_cnt_r <= 8'h00;
    end else if (base_tmo) begin
      wdt_cnt_r <= '0;
      post_cnt_r <= wdt_tmo ? 8'h00 : post_cnt_r + 8'h01;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + WDT_W'(1);
    end
  end

  // Oscillator start-up count and dummy cycle count
  assign ost_done = ost_cnt_r == OST_W'(swc_pkg::OST_CYCLES - 1);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ost_cnt_r <= '0;
      dummy_cnt_r <= 1'b0;
    end else begin
      ost_cnt_r <= (st_r == swc_pkg::SWC_OSC_WAIT)
                   ? ost_cnt_r + OST_W'(1) : '0;
      dummy_cnt_r <= (st_r == swc_pkg::SWC_DUMMY) && !dummy_cnt_r;
    end
  end

  // Sleep state machine next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      swc_pkg::SWC_RUN: begin
        if (sleep_take) begin
          st_nxt = swc_pkg::SWC_SLEEP;
        end
      end
      swc_pkg::SWC_SLEEP: begin
        if (wake_irq || wdt_tmo) begin
          if (!osc_rc_mode) begin
            st_nxt = swc_pkg::SWC_OSC_WAIT;
          end else if (global_irq_enable && wake_irq) begin
            st_nxt = swc_pkg::SWC_DUMMY;
          end else begin
            st_nxt = swc_pkg::SWC_RUN;
          end
        end
      end
      swc_pkg::SWC_OSC_WAIT: begin
        if (ost_done) begin
          st_nxt = vec_pend_r ? swc_pkg::SWC_DUMMY
                              : swc_pkg::SWC_RUN;
        end
      end
      swc_pkg::SWC_DUMMY: begin
        if (dummy_cnt_r) begin
          st_nxt = swc_pkg::SWC_RUN;
        end
      end
      default: st_nxt = swc_pkg::SWC_RUN;
    endcase
    if (master_clear_pin_n_act) begin
      st_nxt = swc_pkg::SWC_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= swc_pkg::SWC_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Vector decision: global enable only steers, never gates, the wake
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vec_pend_r <= 1'b0;
    end else if (st_r == swc_pkg::SWC_SLEEP) begin
      vec_pend_r <= wake_irq && global_irq_enable;
    end
  end

  // Power-down and time-out flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pd_n_r <= 1'b1;
      to_n_r <= 1'b1;
    end else if (sleep_take) begin
      pd_n_r <= 1'b0;
      to_n_r <= 1'b1;
    end else if (wdt_tmo && !master_clear_pin_n_act) begin
      to_n_r <= 1'b0;
      if (st_r != swc_pkg::SWC_SLEEP) begin
        pd_n_r <= 1'b1;
      end
    end else if (core_req.watchdog_clear_instr) begin
      pd_n_r <= 1'b1;
      to_n_r <= 1'b1;
    end
  end

  // Reset, prefetch and resume pulses toward the core
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reset_r <= 1'b0;
      nop_r <= 1'b0;
      resume_r <= 1'b0;
      vector_r <= 1'b0;
      prefetch_r <= '0;
    end else begin
      reset_r <= master_clear_pin_n_act || (wdt_tmo
                 && st_r != swc_pkg::SWC_SLEEP);
      nop_r <= sleep_nop_c;
      // Resume only once the clock is back, not on entry to start-up wait
      resume_r <= !master_clear_pin_n_act && st_r != swc_pkg::SWC_RUN
                  && st_nxt != st_r && st_r != swc_pkg::SWC_DUMMY
                  && st_nxt != swc_pkg::SWC_OSC_WAIT;
      vector_r <= !master_clear_pin_n_act && st_r == swc_pkg::SWC_DUMMY
                  && dummy_cnt_r;
      if (sleep_take) begin
        prefetch_r <= core_req.pc + 14'h0001;
      end
    end
  end

  // Read-out gating for program memory and identification words
  assign id_hit = prog_addr >= swc_pkg::ID_FIRST
                  && prog_addr <= swc_pkg::ID_LAST;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_allow_r <= 1'b0;
      id_wr_r <= 1'b0;
    end else begin
      if (id_hit) begin
        rd_allow_r <= verify_mode;
      end else begin
        rd_allow_r <= !verify_mode
                      || code_protect_fuse == swc_pkg::CP_UNPROGRAMMED;
      end
      id_wr_r <= id_hit && verify_mode;
    end
  end

  // Register bus: option write, status and option read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      option_r <= swc_pkg::OPTION_RST;
      rdata_r <= 8'h00;
    end else begin
      if (master_clear_pin_n_act) begin
        option_r <= swc_pkg::OPTION_RST;
      end else if (reg_wr && reg_addr == swc_pkg::OPTION_OFS) begin
        option_r <= reg_wdata;
      end
      rdata_r <= 8'h00;
      if (reg_rd && reg_addr == swc_pkg::OPTION_OFS) begin
        rdata_r <= option_r;
      end else if (reg_rd && reg_addr == swc_pkg::STATUS_OFS) begin
        rdata_r[swc_pkg::STAT_PD_BIT] <= pd_n_r;
        rdata_r[swc_pkg::STAT_TO_BIT] <= to_n_r;
      end
    end
  end

  // Outputs
  assign reg_rdata = rdata_r;
  assign device_reset = reset_r;
  assign core_halt = st_r != swc_pkg::SWC_RUN;
  assign osc_drive_on = st_r != swc_pkg::SWC_SLEEP;
  assign io_hold = st_r == swc_pkg::SWC_SLEEP
                   || st_r == swc_pkg::SWC_OSC_WAIT;
  assign prefetch_addr = prefetch_r;
  assign sleep_nop = nop_r;
  assign resume_exec = resume_r;
  assign vector_req = vector_r;
  assign vector_addr = swc_pkg::INT_VECTOR;
  assign prog_read_allow = rd_allow_r;
  assign id_write_allow = id_wr_r;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_sleep_flags: assert property (sleep_take |=> !pd_n_r && to_n_r)
    else $error("sleep entry did not update flags");
  chk_sleep_noop: assert property (sleep_nop_c |=>
      st_r == swc_pkg::SWC_RUN && $stable(pd_n_r) && nop_r)
    else $error("no-op sleep changed state");
  chk_wdt_cleared: assert property (sleep_take |=> wdt_cnt_r == '0
      && post_cnt_r == 8'h00)
    else $error("sleep did not clear watchdog");
  chk_wdt_wake: assert property (st_r == swc_pkg::SWC_SLEEP && wdt_tmo
      && !master_clear_pin_n_act |=> !to_n_r && !reset_r && st_r != swc_pkg::SWC_SLEEP)
    else $error("watchdog wake wrong");
  chk_wdt_reset: assert property (st_r == swc_pkg::SWC_RUN && wdt_tmo
      |=> reset_r)
    else $error("watchdog did not reset awake device");
  chk_io_held: assert property (st_r == swc_pkg::SWC_SLEEP
      |-> io_hold && !osc_drive_on)
    else $error("pins or oscillator wrong in sleep");
  chk_ost_length: assert property (st_r == swc_pkg::SWC_OSC_WAIT
      && st_nxt != swc_pkg::SWC_OSC_WAIT && !master_clear_pin_n_act |-> ost_done)
    else $error("start-up delay cut short");
  chk_no_early_run: assert property (st_r == swc_pkg::SWC_OSC_WAIT
      |-> !resume_r)
    else $error("resume during start-up delay");
  chk_vec_dummy: assert property (resume_r
      && st_r == swc_pkg::SWC_DUMMY |-> ##1 st_r == swc_pkg::SWC_DUMMY
      ##1 vector_r)
    else $error("vector not after two dummy cycles");
  chk_prefetch_pc: assert property (sleep_take
      |=> prefetch_r == $past(core_req.pc) + 14'h0001)
    else $error("prefetch address wrong");
  chk_id_locked: assert property (!verify_mode && id_hit
      |=> !rd_allow_r && !id_wr_r)
    else $error("id words reachable outside verify");
  chk_master_clear_pin_n_reset: assert property (master_clear_pin_n_act |=> reset_r
      && st_r == swc_pkg::SWC_RUN)
    else $error("master clear did not reset");

  cov_irq_wake: cover property (st_r == swc_pkg::SWC_SLEEP && wake_irq);
  cov_vector: cover property (vector_r);
  cov_nop: cover property (sleep_nop_c);
  cov_wdt_wake: cover property (st_r == swc_pkg::SWC_SLEEP && wdt_tmo);

endmodule // swc_sleep_ctrl
`default_nettype wire

//--- src/swc_pkg.sv
// Constants and types of the sleep and wake-up controller
package swc_pkg;

  // Register map
  localparam logic [7:0] STATUS_OFS = 8'h03;
  localparam logic [7:0] OPTION_OFS = 8'h81;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_TO_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_PS_LSB = 0;

  // Interrupt sources; only clockless ones may wake the core
  localparam int IRQ_N = 10;
  localparam logic [IRQ_N-1:0] WAKE_CAPABLE = 10'h1FB;

  // Program memory: identification words and address width
  localparam int PADDR_W = 14;
  localparam logic [PADDR_W-1:0] ID_FIRST = 14'h2000;
  localparam logic [PADDR_W-1:0] ID_LAST = 14'h2003;
  localparam logic [PADDR_W-1:0] INT_VECTOR = 14'h0004;
  localparam logic [1:0] CP_UNPROGRAMMED = 2'h3;

  // Timing at 40 MHz
  localparam int CLK_MHZ = 40;
  localparam int OST_TOSC = 1024;
  localparam int OST_CYCLES = OST_TOSC;
  localparam int WDT_PERIOD_US = 18000;
  localparam int WDT_CYCLES_DEF = WDT_PERIOD_US * CLK_MHZ;
  localparam int DUMMY_CYCLES = 2;

  typedef enum logic [1:0] {
    SWC_RUN = 2'h0,
    SWC_SLEEP = 2'h1,
    SWC_OSC_WAIT = 2'h3,
    SWC_DUMMY = 2'h2
  } swc_state_t;

  // Request from the processor core
  typedef struct packed {
    logic sleep_exec;
    logic watchdog_clear_instr;
    logic [PADDR_W-1:0] pc;
  } swc_core_req_t;

  // Interrupt flag and individual enable vectors
  typedef struct packed {
    logic [IRQ_N-1:0] flags;
    logic [IRQ_N-1:0] enables;
  } swc_irq_t;

endpackage

//--- bench/swc_core_model.sv
// Processor core model issuing sleep and watchdog clear requests
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
  input wire logic clk_sys,
  output var swc_pkg::swc_core_req_t core_req
);
  // Idle core request from time zero
  initial core_req = '0;

  // Clear the watchdog, then optionally execute sleep at pc
  task automatic run_sleep(input logic [13:0] pc, input bit do_sleep);
    @(posedge clk_sys);
    core_req.watchdog_clear_instr <= 1'b1;
    @(posedge clk_sys);
    core_req.watchdog_clear_instr <= 1'b0;
    if (do_sleep) begin
      core_req.sleep_exec <= 1'b1;
      core_req.pc <= pc; // Word at pc+1 is prefetched on sleep entry
      @(posedge clk_sys);
      core_req.sleep_exec <= 1'b0;
    end
  endtask
endmodule // swc_core_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int WDT = 60;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  swc_pkg::swc_core_req_t core_req;
  swc_pkg::swc_irq_t irq = '0;
  logic global_irq_enable = 1'b0;
  logic watchdog_enable_fuse = 1'b1;
  logic osc_rc_mode = 1'b1;
  logic master_clear_pin_n = 1'b1;
  logic verify_mode = 1'b0;
  logic [1:0] code_protect_fuse = 2'h3;
  logic [13:0] prog_addr = 14'h0000;
  logic device_reset, core_halt, osc_drive_on, io_hold, sleep_nop;
  logic resume_exec, vector_req, prog_read_allow, id_write_allow;
  logic [13:0] prefetch_addr, vector_addr;
  logic [7:0] d;
  logic [7:0] r;
  logic w;
  int n, i;
  int n_fail = 0;
  int n_compared = 0;
  // Rows: vector, fast wake, source index, its enable, global enable
  logic [7:0] rows [0:10] = '{8'hC3, 8'h46, 8'h0B, 8'h4E, 8'hD3, 8'h56,
                              8'hDB, 8'h5E, 8'hE3, 8'h26, 8'h01};

  // Clock of 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  swc_sleep_ctrl #(.WDT_CYCLES(WDT)) swc_sleep_ctrl_inst (
    .clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .core_req, .irq, .global_irq_enable,
    .watchdog_enable_fuse, .osc_rc_mode, .master_clear_pin_n,
    .verify_mode, .code_protect_fuse, .prog_addr, .device_reset,
    .core_halt, .osc_drive_on, .io_hold, .prefetch_addr, .sleep_nop,
    .resume_exec, .vector_req, .vector_addr, .prog_read_allow,
    .id_write_allow
  );
  swc_core_model swc_core_model_inst (.clk_sys, .core_req);

  // Verdict and end of run
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register bus write and read
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Bounded wait for resume, no-op or reset pulse
  task automatic wsig(input int sel, input int lim, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
      s = (sel == 0) ? resume_exec : (sel == 1) ? sleep_nop : device_reset;
      if (cnt > lim) begin
        n_fail++;
        final_report();
      end
    end while (s !== 1'b1);
  endtask

  // Program address gating after mode change
  task automatic gate(input logic v, input logic [1:0] c,
                      input logic [13:0] a, input logic [1:0] e);
    @(posedge clk_sys);
    verify_mode <= v;
    code_protect_fuse <= c;
    prog_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 chk({prog_read_allow, id_write_allow}, e);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(swc_pkg::STATUS_OFS, d);
    chk(d[4:3], 2'h3);
    rd(swc_pkg::OPTION_OFS, d);
    chk(d, 8'hFF);
    rd(8'h55, d);
    chk(d, 8'h00);
    wr(swc_pkg::OPTION_OFS, 8'h00);
    for (i = 0; i < 11; i++) begin
      r = rows[i];
      global_irq_enable <= r[0];
      irq.flags <= 10'h000;
      irq.enables <= r[1] ? (10'h001 << r[5:2]) : 10'h000;
      swc_core_model_inst.run_sleep(14'h0100 + 14'(i), 1'b1);
      #1;
      chk(core_halt, 1'b1);
      chk(osc_drive_on, 1'b0);
      chk(io_hold, 1'b1);
      chk(prefetch_addr, 14'h0101 + 14'(i));
      rd(swc_pkg::STATUS_OFS, d);
      chk(d[4:3], 2'h2);
      irq.flags <= 10'h001 << r[5:2];
      wsig(0, 200, n);
      w = r[6];
      chk(w ? (n <= 3) : (n > 20), 1'b1);
      repeat (2) @(posedge clk_sys);
      #1 chk(vector_req, r[7]);
      chk(vector_addr, 14'h0004);
      if (!w) begin
        rd(swc_pkg::STATUS_OFS, d);
        chk(d[4:3], 2'h0);
      end
    end
    // Pending enabled source turns sleep into a no-op
    irq.enables <= 10'h001;
    irq.flags <= 10'h001;
    swc_core_model_inst.run_sleep(14'h0200, 1'b1);
    #1 chk(sleep_nop, 1'b1);
    chk(core_halt, 1'b0);
    rd(swc_pkg::STATUS_OFS, d);
    chk(d[4:3], 2'h3);
    irq.flags <= 10'h000;
    // Watchdog time-out while awake resets the device
    swc_core_model_inst.run_sleep(14'h0000, 1'b0);
    wsig(2, WDT + 10, n);
    chk(n > WDT - 5, 1'b1);
    rd(swc_pkg::STATUS_OFS, d);
    chk(d[4:3], 2'h1);
    // Crystal mode wake waits for the oscillator start-up
    watchdog_enable_fuse <= 1'b0;
    osc_rc_mode <= 1'b0;
    global_irq_enable <= 1'b0;
    swc_core_model_inst.run_sleep(14'h0300, 1'b1);
    irq.flags <= 10'h001;
    wsig(0, 1100, n);
    chk((n >= 1024) && (n <= 1027), 1'b1);
    repeat (2) @(posedge clk_sys);
    #1 chk(vector_req, 1'b0);
    irq.flags <= 10'h000;
    // Master clear during sleep resets state and option, not the status flags
    osc_rc_mode <= 1'b1;
    swc_core_model_inst.run_sleep(14'h0400, 1'b1);
    master_clear_pin_n <= 1'b0;
    wsig(2, 8, n);
    master_clear_pin_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk(core_halt, 1'b0);
    rd(swc_pkg::OPTION_OFS, d);
    chk(d, 8'hFF);
    rd(swc_pkg::STATUS_OFS, d);
    chk(d[4:3], 2'h2);
    // Power-up reset in mid-run, taken while asleep
    wr(swc_pkg::OPTION_OFS, 8'h0F);
    swc_core_model_inst.run_sleep(14'h0500, 1'b1);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1 chk({core_halt, osc_drive_on, io_hold, device_reset}, 4'h4);
    rd(swc_pkg::STATUS_OFS, d);
    chk(d[4:3], 2'h3);
    rd(swc_pkg::OPTION_OFS, d);
    chk(d, 8'hFF);
    // Watchdog with the prescaler assigned, ratio two
    watchdog_enable_fuse <= 1'b1;
    wr(swc_pkg::OPTION_OFS, 8'h09);
    swc_core_model_inst.run_sleep(14'h0000, 1'b0);
    wsig(2, 2 * WDT + 10, n);
    chk(16'(n), 16'(2 * WDT));
    // Read-out and identification word gating
    gate(1'b0, 2'h3, 14'h0100, 2'h2);
    gate(1'b0, 2'h3, 14'h2001, 2'h0);
    gate(1'b1, 2'h0, 14'h0100, 2'h0);
    gate(1'b1, 2'h3, 14'h0100, 2'h2);
    gate(1'b1, 2'h3, 14'h2003, 2'h3);
    gate(1'b1, 2'h3, 14'h2004, 2'h2);
    final_report();
  end
endmodule // testbench
`default_nettype wire
